// >>> nvsc_host.sv
// Purpose: host controller driving an 8K x 8 nv static ram through its pins
// Assumes: pins synchronous to CLK; power-good level from the board supervisor
// Notes:   one request at a time; READY high when a new request is taken
`timescale 1ns/1ps
`default_nettype none

module nvsc_host (
   input  wire logic                        CLK,
   input  wire logic                        RST_B,
   input  wire logic                        POWER_GOOD,
   input  wire logic                        REQ_VALID,
   input  wire nvsc_pkg::nvsc_req_type      REQ,
   output logic                             READY,
   output logic                             RDATA_VALID,
   output logic [`NVSC_DATA_W-1:0]          RDATA,
   output logic                             STORE_REFUSED,
   output logic                             NV_BUSY,
   output logic [`NVSC_ADDR_W-1:0]          MEM_ADDR,
   output logic                             MEM_CHIP_SEL_N,
   output logic                             MEM_WRITE_N,
   output logic                             MEM_OUT_EN_N,
   output logic                             MEM_NONVOL_ENABLE_N,
   output logic [`NVSC_DATA_W-1:0]          MEM_DQ_OUT,
   output logic                             MEM_DQ_OE,
   input  wire logic [`NVSC_DATA_W-1:0]     MEM_DQ_IN
);

   typedef enum logic [3:0] {
      ST_POWERUP,
      ST_IDLE,
      ST_RD_ACC,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_WR_TAIL,
      ST_NV_SETUP,
      ST_NV_PULSE,
      ST_NV_WAIT
   } nvsc_state_type;

   nvsc_state_type                  state_reg, state_next;
   nvsc_pkg::nvsc_strobe_type       stb_reg, stb_next;
   logic [`NVSC_ADDR_W-1:0]         addr_reg, addr_next;
   logic [`NVSC_DATA_W-1:0]         dout_reg, dout_next;
   logic                            doe_reg, doe_next;
   logic [`NVSC_DATA_W-1:0]         rdata_reg, rdata_next;
   logic                            rvalid_reg, rvalid_next;
   logic                            refused_reg, refused_next;
   logic                            ready_reg, ready_next;
   logic                            is_store_reg, is_store_next;
   logic                            pg_seen_reg, pg_seen_next;
   logic                            tmr_load;
   logic [`NVSC_CNT_W-1:0]          tmr_value;
   logic                            tmr_done;
   logic                            busy_reg, busy_next;
   localparam nvsc_pkg::nvsc_strobe_type STB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};
   // ----------------------------------------
   // phase timer
   // ----------------------------------------
   nvsc_timer u_timer (
      .clk   (CLK),
      .rst_b (RST_B),
      .load  (tmr_load),
      .value (tmr_value),
      .done  (tmr_done)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // next values of the cycle sequencer and pin drivers
   always_comb begin
      state_next    = state_reg;
      stb_next      = stb_reg;
      addr_next     = addr_reg;
      dout_next     = dout_reg;
      doe_next      = doe_reg;
      rdata_next    = rdata_reg;
      rvalid_next   = 1'b0;
      refused_next  = 1'b0;
      ready_next    = 1'b0;
      is_store_next = is_store_reg;
      pg_seen_next  = pg_seen_reg;
      tmr_load      = 1'b0;
      tmr_value     = '0;
      case (state_reg)
         ST_POWERUP: begin
            // wait the automatic recall after the supply is good
            stb_next = STB_IDLE;
            doe_next = 1'b0;
            if (!pg_seen_reg) begin
               if (POWER_GOOD) begin
                  pg_seen_next = 1'b1;
                  tmr_load     = 1'b1;
                  tmr_value    = `NVSC_CNT_W'(`NVSC_RECALL_DUR_CYC);
               end
            end else if (tmr_done) begin
               state_next = ST_IDLE;
               ready_next = 1'b1;
            end
         end
         ST_IDLE: begin
            ready_next = 1'b1;
            stb_next   = STB_IDLE;
            doe_next   = 1'b0;
            if (REQ_VALID && ready_reg) begin
               ready_next = 1'b0;
               addr_next  = REQ.addr;
               tmr_load   = 1'b1;
               case (REQ.cmd)
                  nvsc_pkg::NVSC_CMD_READ: begin
                     stb_next.chip_sel_n = 1'b0;
                     stb_next.out_en_n   = 1'b0;
                     tmr_value  = `NVSC_CNT_W'(`NVSC_T_ACC_CYC);
                     state_next = ST_RD_ACC;
                  end
                  nvsc_pkg::NVSC_CMD_WRITE: begin
                     stb_next.write_n = 1'b0;
                     dout_next  = REQ.wdata;
                     doe_next   = 1'b1;
                     tmr_value  = `NVSC_CNT_W'(1);
                     state_next = ST_WR_SETUP;
                  end
                  nvsc_pkg::NVSC_CMD_STORE: begin
                     if (!POWER_GOOD) begin
                        refused_next = 1'b1;
                        ready_next   = 1'b1;
                        tmr_load     = 1'b0;
                     end else begin
                        stb_next.out_en_n        = 1'b1;
                        stb_next.nonvol_enable_n = 1'b0;
                        stb_next.chip_sel_n      = 1'b0;
                        is_store_next = 1'b1;
                        tmr_value     = `NVSC_CNT_W'(1);
                        state_next    = ST_NV_SETUP;
                     end
                  end
                  nvsc_pkg::NVSC_CMD_RECALL: begin
                     stb_next.out_en_n   = 1'b0;
                     stb_next.chip_sel_n = 1'b0;
                     is_store_next = 1'b0;
                     tmr_value     = `NVSC_CNT_W'(1);
                     state_next    = ST_NV_SETUP;
                  end
                  default: begin
                     // no operation: nothing to drive
                     ready_next = 1'b1;
                     tmr_load   = 1'b0;
                  end
               endcase
            end
         end
         ST_RD_ACC: begin
            if (tmr_done) begin
               rdata_next  = MEM_DQ_IN;
               rvalid_next = 1'b1;
               stb_next    = STB_IDLE;
               tmr_load    = 1'b1;
               tmr_value   = `NVSC_CNT_W'(1);
               state_next  = ST_WR_TAIL;
            end
         end
         ST_WR_SETUP: begin
            // chip select falls only after write is already low
            if (tmr_done) begin
               stb_next.chip_sel_n = 1'b0;
               tmr_load   = 1'b1;
               tmr_value  = `NVSC_CNT_W'(`NVSC_T_CW_CYC);
               state_next = ST_WR_PULSE;
            end
         end
         ST_WR_PULSE: begin
            if (tmr_done) begin
               stb_next.chip_sel_n = 1'b1;
               tmr_load   = 1'b1;
               tmr_value  = `NVSC_CNT_W'(`NVSC_T_WC_CYC - `NVSC_T_CW_CYC);
               state_next = ST_WR_TAIL;
            end
         end
         ST_WR_TAIL: begin
            // hold address and data past the end of write, then release
            stb_next.write_n = 1'b1;
            if (tmr_done) begin
               doe_next   = 1'b0;
               state_next = ST_IDLE;
               ready_next = 1'b1;
            end
         end
         ST_NV_SETUP: begin
            // strobes settled, now assert the initiating strobe
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (is_store_reg) begin
                  stb_next.write_n = 1'b0;
                  tmr_value = `NVSC_CNT_W'(`NVSC_STORE_INIT_CYC);
               end else begin
                  stb_next.nonvol_enable_n = 1'b0;
                  tmr_value = `NVSC_CNT_W'(`NVSC_RECALL_INIT_CYC);
               end
               state_next = ST_NV_PULSE;
            end
         end
         ST_NV_PULSE: begin
            if (is_store_reg && !POWER_GOOD) begin
               stb_next   = STB_IDLE;
               state_next = ST_IDLE;
               refused_next = 1'b1;
               ready_next   = 1'b1;
            end else if (tmr_done) begin
               stb_next  = STB_IDLE;
               tmr_load  = 1'b1;
               tmr_value = is_store_reg ? `NVSC_CNT_W'(`NVSC_STORE_DUR_CYC)
                                        : `NVSC_CNT_W'(`NVSC_RECALL_DUR_CYC);
               state_next = ST_NV_WAIT;
            end
         end
         ST_NV_WAIT: begin
            // no access until the non-volatile cycle is over
            if (tmr_done) begin
               state_next = ST_IDLE;
               ready_next = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      busy_next = (state_next == ST_NV_WAIT) && is_store_next;
   end
   // registers of the sequencer
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg    <= ST_POWERUP;
         stb_reg      <= '{1'b1, 1'b1, 1'b1, 1'b1};
         addr_reg     <= '0;
         dout_reg     <= '0;
         doe_reg      <= 1'b0;
         rdata_reg    <= '0;
         rvalid_reg   <= 1'b0;
         refused_reg  <= 1'b0;
         ready_reg    <= 1'b0;
         is_store_reg <= 1'b0;
         pg_seen_reg  <= 1'b0;
         busy_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         stb_reg      <= stb_next;
         addr_reg     <= addr_next;
         dout_reg     <= dout_next;
         doe_reg      <= doe_next;
         rdata_reg    <= rdata_next;
         rvalid_reg   <= rvalid_next;
         refused_reg  <= refused_next;
         ready_reg    <= ready_next;
         is_store_reg <= is_store_next;
         pg_seen_reg  <= pg_seen_next;
         busy_reg     <= busy_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // all straight from flip-flops
   assign READY               = ready_reg;
   assign RDATA_VALID         = rvalid_reg;
   assign RDATA               = rdata_reg;
   assign STORE_REFUSED       = refused_reg;
   assign NV_BUSY             = busy_reg;
   assign MEM_ADDR            = addr_reg;
   assign MEM_CHIP_SEL_N      = stb_reg.chip_sel_n;
   assign MEM_WRITE_N         = stb_reg.write_n;
   assign MEM_OUT_EN_N        = stb_reg.out_en_n;
   assign MEM_NONVOL_ENABLE_N = stb_reg.nonvol_enable_n;
   assign MEM_DQ_OUT          = dout_reg;
   assign MEM_DQ_OE           = doe_reg;

endmodule

`default_nettype wire

// >>> nvsc_host_props.sv
// Purpose: pin timing checks for the nv sram host controller
// Assumes: nvsc_map.svh macros visible; one clock domain
// Notes:   bound to nvsc_host from the testbench top
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_map.svh"

module nvsc_host_props (
   input wire logic                     CLK,
   input wire logic                     RST_B,
   input wire logic                     POWER_GOOD,
   input wire logic                     READY,
   input wire logic                     STORE_REFUSED,
   input wire logic                     NV_BUSY,
   input wire logic [`NVSC_ADDR_W-1:0]  MEM_ADDR,
   input wire logic                     MEM_CHIP_SEL_N,
   input wire logic                     MEM_WRITE_N,
   input wire logic                     MEM_OUT_EN_N,
   input wire logic                     MEM_NONVOL_ENABLE_N,
   input wire logic [`NVSC_DATA_W-1:0]  MEM_DQ_OUT,
   input wire logic                     MEM_DQ_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // cycles with chip select and write both low, for the width check
   logic [7:0] cs_low_cnt;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cs_low_cnt <= 8'h00;
      end else if (MEM_CHIP_SEL_N || MEM_WRITE_N) begin
         cs_low_cnt <= 8'h00;
      end else if (cs_low_cnt != 8'hff) begin
         cs_low_cnt <= cs_low_cnt + 8'h01;
      end
   end

   // ----------------------------------------
   // strobe and bus relations
   // ----------------------------------------
   chk_addr_moves: assert property (!$stable(MEM_ADDR) |-> MEM_CHIP_SEL_N || MEM_WRITE_N)
      else $error("address moved during a selected write");
   chk_write_early: assert property ($fell(MEM_CHIP_SEL_N) && MEM_DQ_OE |-> !$past(MEM_WRITE_N))
      else $error("write strobe not low before chip select fell");
   chk_cs_width: assert property ($rose(MEM_CHIP_SEL_N) && !MEM_WRITE_N && MEM_DQ_OE |-> cs_low_cnt >= `NVSC_T_CW_CYC)
      else $error("chip select low time too short in write");
   chk_addr_setup: assert property ($rose(MEM_CHIP_SEL_N) && !MEM_WRITE_N && MEM_DQ_OE |-> MEM_ADDR == $past(MEM_ADDR, 9))
      else $error("address not held over the write");
   chk_data_setup: assert property ($rose(MEM_CHIP_SEL_N) && !MEM_WRITE_N && MEM_DQ_OE
                                    |-> $past(MEM_DQ_OE, 8) && MEM_DQ_OUT == $past(MEM_DQ_OUT, 8))
      else $error("write data set-up too short");
   chk_store_setup: assert property ($fell(MEM_WRITE_N) && !MEM_NONVOL_ENABLE_N
                                     |-> MEM_OUT_EN_N && !MEM_CHIP_SEL_N && !$past(MEM_NONVOL_ENABLE_N))
      else $error("store strobes not set before write fell");
   chk_store_hold: assert property ($rose(MEM_NONVOL_ENABLE_N) && $past(MEM_OUT_EN_N) && POWER_GOOD
                                    |-> !$past(MEM_WRITE_N, 12))
      else $error("store initiation shorter than required");
   chk_recall_setup: assert property ($fell(MEM_NONVOL_ENABLE_N) && !MEM_OUT_EN_N
                                      |-> !$past(MEM_OUT_EN_N) && !$past(MEM_CHIP_SEL_N) && !MEM_DQ_OE)
      else $error("recall strobes not set before nonvol enable fell");
   chk_recall_hold: assert property ($fell(MEM_NONVOL_ENABLE_N) && !MEM_OUT_EN_N
                                     |-> (!MEM_NONVOL_ENABLE_N && !MEM_CHIP_SEL_N && MEM_WRITE_N)[*7])
      else $error("recall request not held long enough");
   chk_busy_idle: assert property (NV_BUSY |-> MEM_CHIP_SEL_N && !READY && !MEM_DQ_OE)
      else $error("access while store runs");
   chk_refuse_idle: assert property (STORE_REFUSED |=> !NV_BUSY && MEM_WRITE_N && MEM_NONVOL_ENABLE_N)
      else $error("refused store left strobes active");

   // main scenarios reached
   cov_write: cover property ($rose(MEM_CHIP_SEL_N) && !MEM_WRITE_N && MEM_DQ_OE);
   cov_store: cover property ($rose(NV_BUSY));
   cov_recall: cover property ($fell(MEM_NONVOL_ENABLE_N) && !MEM_OUT_EN_N);
   cov_refuse: cover property (STORE_REFUSED);
endmodule
`default_nettype wire

// >>> nvsc_host_tb_top.sv
// Purpose: self-checking bench for the nv sram host controller
// Assumes: store wait is too long to finish; a store is checked at its start
// Notes:   expected memory kept in an associative array beside the model
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_map.svh"

module nvsc_host_tb_top;
   logic                    CLK = 1'b0, RST_B = 1'b0, POWER_GOOD = 1'b0, REQ_VALID = 1'b0;
   nvsc_pkg::nvsc_req_type  REQ = '0;
   logic                    READY, RDATA_VALID, STORE_REFUSED, NV_BUSY, MEM_DQ_OE, dev_oe;
   logic                    MEM_CHIP_SEL_N, MEM_WRITE_N, MEM_OUT_EN_N, MEM_NONVOL_ENABLE_N;
   logic [7:0]              RDATA, MEM_DQ_OUT, dev_dq, mem_dq;
   logic [12:0]             MEM_ADDR;
   logic [12:0]             wq[$];
   logic [7:0]              exp_mem [int];
   int                      n_errors = 0, checked = 0, cnt;
   integer                  seed = 32'h7298;

   // ----------------------------------------
   // clock, wire resolution, instances
   // ----------------------------------------
   always #2 CLK = ~CLK;
   assign mem_dq = MEM_DQ_OE ? MEM_DQ_OUT : dev_dq;

   // host and device never drive the data pins together
   always @(negedge CLK) begin
      if (RST_B && MEM_DQ_OE && dev_oe) chk(32'h1, 32'h0);
   end

   nvsc_host i_dut (.CLK(CLK), .RST_B(RST_B), .POWER_GOOD(POWER_GOOD), .REQ_VALID(REQ_VALID), .REQ(REQ),
      .READY(READY), .RDATA_VALID(RDATA_VALID), .RDATA(RDATA), .STORE_REFUSED(STORE_REFUSED), .NV_BUSY(NV_BUSY),
      .MEM_ADDR(MEM_ADDR), .MEM_CHIP_SEL_N(MEM_CHIP_SEL_N), .MEM_WRITE_N(MEM_WRITE_N), .MEM_OUT_EN_N(MEM_OUT_EN_N),
      .MEM_NONVOL_ENABLE_N(MEM_NONVOL_ENABLE_N), .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE), .MEM_DQ_IN(mem_dq));
   nvsc_nvram_model i_dev (.clk(CLK), .power_good(POWER_GOOD), .addr(MEM_ADDR), .chip_sel_n(MEM_CHIP_SEL_N),
      .write_n(MEM_WRITE_N), .out_en_n(MEM_OUT_EN_N), .nonvol_enable_n(MEM_NONVOL_ENABLE_N), .dq_in(mem_dq),
      .dq_out(dev_dq), .dq_oe(dev_oe));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [7:0] pat(input int a);
      return 8'(a * 7 + 3);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wait_sig(input int limit, input logic pulse, output int n);
      n = 0;
      while ((pulse ? STORE_REFUSED : READY) !== 1'b1 && n < limit) begin
         @(negedge CLK);
         n++;
      end
   endtask

   task automatic issue(input nvsc_pkg::nvsc_cmd_type c, input logic [12:0] a, input logic [7:0] d);
      wait_sig(6000, 1'b0, cnt);
      REQ.cmd = c;
      REQ.addr = a;
      REQ.wdata = d;
      REQ_VALID = 1'b1;
      @(negedge CLK);
      REQ_VALID = 1'b0;
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      issue(nvsc_pkg::NVSC_CMD_WRITE, a, d);
      exp_mem[a] = d;
      wq.push_back(a);
   endtask

   task automatic rd(input logic [12:0] a);
      int n;
      issue(nvsc_pkg::NVSC_CMD_READ, a, 8'h00);
      n = 0;
      while (RDATA_VALID !== 1'b1 && n < 20) begin
         @(negedge CLK);
         n++;
      end
      chk(RDATA, exp_mem.exists(a) ? exp_mem[a] : pat(a));
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge CLK);
      chk({MEM_CHIP_SEL_N, MEM_WRITE_N, MEM_OUT_EN_N, MEM_NONVOL_ENABLE_N, MEM_DQ_OE, READY}, 6'h3c);
      RST_B = 1'b1;
      repeat (3) @(negedge CLK);
      POWER_GOOD = 1'b1;
      wait_sig(6000, 1'b0, cnt);
      chk(cnt >= `NVSC_RECALL_DUR_CYC, 1'b1);
      rd(13'h0000);
      rd(13'h1fff);
      wr(13'h0000, 8'h00);
      wr(13'h1fff, 8'hff);
      repeat (8) wr(13'($random(seed)), 8'($random(seed)));
      foreach (wq[i]) rd(wq[i]);
      issue(nvsc_pkg::NVSC_CMD_NOP, 13'h0000, 8'h00);
      chk(READY, 1'b1);
      @(negedge CLK);
      issue(nvsc_pkg::NVSC_CMD_RECALL, 13'h0000, 8'h00);
      exp_mem.delete();
      foreach (wq[i]) rd(wq[i]);
      POWER_GOOD = 1'b0;
      issue(nvsc_pkg::NVSC_CMD_STORE, 13'h0000, 8'h00);
      wait_sig(20, 1'b1, cnt);
      chk(cnt < 20, 1'b1);
      POWER_GOOD = 1'b1;
      repeat (4100) @(negedge CLK);
      wr(13'h0aaa, 8'h3c);
      issue(nvsc_pkg::NVSC_CMD_STORE, 13'h0000, 8'h00);
      repeat (4) @(negedge CLK);
      POWER_GOOD = 1'b0;
      wait_sig(20, 1'b1, cnt);
      chk(cnt < 20, 1'b1);
      chk(i_dev.ee[13'h0aaa], pat(13'h0aaa));
      RST_B = 1'b0;
      repeat (8) @(negedge CLK);
      RST_B = 1'b1;
      POWER_GOOD = 1'b1;
      exp_mem.delete();
      wr(13'h0555, 8'hc3);
      issue(nvsc_pkg::NVSC_CMD_STORE, 13'h0000, 8'h00);
      repeat (20) @(negedge CLK);
      chk({NV_BUSY, READY, MEM_CHIP_SEL_N}, 3'b101);
      chk(i_dev.ee[13'h0555], 8'hc3);
      REQ.cmd = nvsc_pkg::NVSC_CMD_READ;
      REQ_VALID = 1'b1;
      repeat (5) @(negedge CLK);
      REQ_VALID = 1'b0;
      chk({MEM_CHIP_SEL_N, NV_BUSY}, 2'b11);
      end_sim();
   end

   // hang guard
   initial begin
      #400000;
      n_errors++;
      end_sim();
   end
endmodule

bind nvsc_host nvsc_host_props i_props (.CLK(CLK), .RST_B(RST_B), .POWER_GOOD(POWER_GOOD), .READY(READY),
   .STORE_REFUSED(STORE_REFUSED), .NV_BUSY(NV_BUSY), .MEM_ADDR(MEM_ADDR), .MEM_CHIP_SEL_N(MEM_CHIP_SEL_N),
   .MEM_WRITE_N(MEM_WRITE_N), .MEM_OUT_EN_N(MEM_OUT_EN_N), .MEM_NONVOL_ENABLE_N(MEM_NONVOL_ENABLE_N),
   .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE));
`default_nettype wire

// >>> nvsc_map.svh
// Purpose: timing counts and field layout for the nv sram host controller
// Assumes: clock of 250 MHz, period 4 ns
// Notes:   times in their own unit, cycle counts derived from them
`ifndef NVSC_MAP_SVH
`define NVSC_MAP_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define NVSC_CLK_PERIOD_PS      4000

// ----------------------------------------
// device geometry
// ----------------------------------------
`define NVSC_ADDR_W             13
`define NVSC_DATA_W             8

// ----------------------------------------
// write timing in ns, cycles rounded up
// ----------------------------------------
`define NVSC_T_WC_NS            45
`define NVSC_T_CW_NS            35
`define NVSC_T_DW_NS            30
`define NVSC_T_AS_NS            0
`define NVSC_T_WC_CYC           (((`NVSC_T_WC_NS * 1000) + `NVSC_CLK_PERIOD_PS - 1) / `NVSC_CLK_PERIOD_PS)
`define NVSC_T_CW_CYC           (((`NVSC_T_CW_NS * 1000) + `NVSC_CLK_PERIOD_PS - 1) / `NVSC_CLK_PERIOD_PS)

// ----------------------------------------
// read timing in ns
// ----------------------------------------
`define NVSC_T_ACC_NS           45
`define NVSC_T_ACC_CYC          (((`NVSC_T_ACC_NS * 1000) + `NVSC_CLK_PERIOD_PS - 1) / `NVSC_CLK_PERIOD_PS)

// ----------------------------------------
// non-volatile timing
// ----------------------------------------
`define NVSC_STORE_INIT_NS      45
`define NVSC_RECALL_INIT_NS     25
`define NVSC_STORE_DUR_MS       10
`define NVSC_RECALL_DUR_US      20
`define NVSC_STORE_INIT_CYC     (((`NVSC_STORE_INIT_NS * 1000) + `NVSC_CLK_PERIOD_PS - 1) / `NVSC_CLK_PERIOD_PS)
`define NVSC_RECALL_INIT_CYC    (((`NVSC_RECALL_INIT_NS * 1000) + `NVSC_CLK_PERIOD_PS - 1) / `NVSC_CLK_PERIOD_PS)
`define NVSC_STORE_DUR_CYC      ((`NVSC_STORE_DUR_MS * 64'd1000000000) / `NVSC_CLK_PERIOD_PS)
`define NVSC_RECALL_DUR_CYC     ((`NVSC_RECALL_DUR_US * 1000000) / `NVSC_CLK_PERIOD_PS)

// ----------------------------------------
// counter width
// ----------------------------------------
`define NVSC_CNT_W              24

`endif

// >>> nvsc_nvram_model.sv
// Purpose: behavioural model of the 8K x 8 nv static ram
// Assumes: strobes change on rising clock edges, sampled here on falling ones
// Notes:   released data pins show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_map.svh"

module nvsc_nvram_model #(
   parameter int ST_INIT = 12,
   parameter int RC_INIT = 7,
   parameter int ST_CYC  = 100000,
   parameter int RC_CYC  = 4000
) (
   input wire logic                     clk,
   input wire logic                     power_good,
   input wire logic [`NVSC_ADDR_W-1:0]  addr,
   input wire logic                     chip_sel_n,
   input wire logic                     write_n,
   input wire logic                     out_en_n,
   input wire logic                     nonvol_enable_n,
   input wire logic [`NVSC_DATA_W-1:0]  dq_in,
   output logic [`NVSC_DATA_W-1:0]      dq_out,
   output logic                         dq_oe
);
   logic [7:0]  sram [8192];
   logic [7:0]  ee [8192];
   int          busy_cnt = 0;
   int          st_cnt = 0;
   int          rc_cnt = 0;
   logic        rc_run = 0, pg_prev = 0, cs_prev = 1, wr_prev = 0, early = 0;
   logic [12:0] wa;
   logic [7:0]  wd;
   logic [7:0]  last = 8'h00;

   // non-volatile array starts with a known pattern
   initial for (int i = 0; i < 8192; i++) begin
      sram[i] = 8'h00;
      ee[i] = 8'(i * 7 + 3);
   end

   // drive only in a plain read, never in early write or nv cycles
   assign dq_oe = busy_cnt == 0 && !chip_sel_n && write_n && !out_en_n && nonvol_enable_n && !early;
   assign dq_out = dq_oe ? sram[addr] : ~last;

   // mode decode, nv cycle timing and write capture
   always @(negedge clk) begin
      last = dq_out;
      if (power_good && !pg_prev) begin
         busy_cnt = RC_CYC;
         rc_run = 1'b1;
      end
      if (busy_cnt != 0) begin
         if (!power_good && !rc_run) busy_cnt = 0;
         else busy_cnt--;
         if (busy_cnt == 0 && rc_run) begin
            sram = ee;
            rc_run = 1'b0;
         end
      end else if (!chip_sel_n && !write_n && out_en_n && !nonvol_enable_n) begin
         st_cnt = power_good ? st_cnt + 1 : 0;
      end else if (!chip_sel_n && write_n && !out_en_n && !nonvol_enable_n) begin
         rc_cnt++;
         if (rc_cnt == RC_INIT) begin
            busy_cnt = RC_CYC;
            rc_run = 1'b1;
         end
      end else begin
         if (st_cnt >= ST_INIT) begin
            ee = sram;
            busy_cnt = ST_CYC;
         end
         st_cnt = 0;
         rc_cnt = 0;
      end
      if (wr_prev && (chip_sel_n || write_n) && busy_cnt == 0) sram[wa] = wd;
      wr_prev = !chip_sel_n && !write_n && nonvol_enable_n;
      early = !chip_sel_n && (early || (cs_prev && !write_n));
      wa = addr;
      wd = dq_in;
      cs_prev = chip_sel_n;
      pg_prev = power_good;
   end
endmodule
`default_nettype wire

// >>> nvsc_pkg.sv
// Purpose: types for the nv sram host controller
// Assumes: nvsc_map.svh included first
// Notes:   none
`include "nvsc_map.svh"

package nvsc_pkg;

   // host command codes
   typedef enum logic [2:0] {
      NVSC_CMD_READ,
      NVSC_CMD_WRITE,
      NVSC_CMD_STORE,
      NVSC_CMD_RECALL,
      NVSC_CMD_NOP
   } nvsc_cmd_type;

   // one request from the user side
   typedef struct packed {
      nvsc_cmd_type                  cmd;
      logic [`NVSC_ADDR_W-1:0]       addr;
      logic [`NVSC_DATA_W-1:0]       wdata;
   } nvsc_req_type;

   // strobes toward the device, all active low
   typedef struct packed {
      logic chip_sel_n;
      logic write_n;
      logic out_en_n;
      logic nonvol_enable_n;
   } nvsc_strobe_type;

endpackage

// >>> nvsc_timer.sv
// Purpose: load-and-count-down timer used for every phase of a cycle
// Assumes: one clock, asynchronous active-low reset
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none

module nvsc_timer (
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire logic                    load,
   input  wire logic [`NVSC_CNT_W-1:0]  value,
   output logic                         done
);

   logic [`NVSC_CNT_W-1:0] cnt_reg;
   logic [`NVSC_CNT_W-1:0] cnt_next;

   // ----------------------------------------
   // count
   // ----------------------------------------
   // load wins, otherwise count down to zero
   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = value;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - `NVSC_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign done = (cnt_reg == '0);

endmodule

`default_nettype wire
